//--- output_terminal_function_selector.sv
// Chosen here: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - five terminals each with own select code
// - fifth terminal only with expansion card
// - code 0 keeps terminal inactive
// - code 1 active in run or inching
// - code 2 frequency reach within width
// - code 3 detect level a with hysteresis
// - code 4 detect level b with hysteresis
// - code 5 active when running reverse
// - code 6 active in inching only
// - code 7 active in fault state
// - code 8 active when ready
// - code 9 both frequencies at upper limit
// - code 10 both frequencies at lower limit
// - code 11 current limit with five percent
// - code 12 overvoltage stall with ten volts
// - code 13 single pass sequencer finished
// - code 13 limited repeat sequencer finished
// - code 14 pulse count reaches set count
// - code 15 pulse count reaches designated
module output_terminal_function_selector
    import outsel_pkg::*;
(
    input  wire logic        mclk,                   // control clock, 250 MHz
    input  wire logic        rstn,                   // sync reset, active low
    input  wire logic        hsel,                   // ahb slave select
    input  wire logic [31:0] haddr,                  // ahb address
    input  wire logic [1:0]  htrans,                 // ahb transfer type
    input  wire logic        hwrite,                 // ahb write
    input  wire logic [2:0]  hsize,                  // ahb size
    input  wire logic [31:0] hwdata,                 // ahb write data
    input  wire logic        hready,                 // ahb bus ready
    output logic      [31:0] hrdata,                 // ahb read data
    output logic             hreadyout,              // ahb slave ready
    output logic             hresp,                  // ahb response
    input  wire logic        exp_card_fitted,        // expansion card present
    input  wire drive_stat_s drv,                    // drive status
    output logic             digital_out_one,        // terminal one
    output logic             digital_out_two,        // terminal two
    output logic             relay_out_one,          // relay one
    output logic             relay_out_two,          // relay two
    output logic             expansion_digital_out   // expansion terminal
);

    ////////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        ahb_cap_s                     cap;        // bus capture
        logic [NUM_OUTS-1:0][SEL_W-1:0] sel;      // function selects
        logic [MON_W-1:0] reach_w;                // reach width
        logic [MON_W-1:0] lvl_a;                  // detect level a
        logic [MON_W-1:0] hyst_a;                 // hysteresis a
        logic [MON_W-1:0] lvl_b;                  // detect level b
        logic [MON_W-1:0] hyst_b;                 // hysteresis b
        logic [MON_W-1:0] upper;                  // upper freq limit
        logic [MON_W-1:0] lower;                  // lower freq limit
        logic [MON_W-1:0] cur_lim;                // current limit level
        logic [MON_W-1:0] ov_stall;               // overvoltage stall volts
        logic [MON_W-1:0] set_cnt;                // set count value
        logic [MON_W-1:0] des_cnt;                // designated count value
        logic             det_a;                  // hysteresis flag a
        logic             det_b;                  // hysteresis flag b
        logic             cur_f;                  // current limit flag
        logic             ov_f;                   // overvoltage flag
        logic [NUM_OUTS-1:0] outs;                // registered terminals
        logic [31:0]      rdata;                  // read data
    } state_s;

    state_s st_q;   // registered state
    state_s st_d;   // next state

    // refuse a layout the decode and status word cannot serve
    if (NUM_OUTS != 5 || SEL_W != 16 || MON_W != 16) begin : g_cfg_check
        $error("unsupported terminal count or field width");
    end

    ////////////////////////////////////////////////////////////////////////////
    // derived conditions
    logic [MON_W-1:0] abs_out;    // magnitude of output frequency
    logic [MON_W-1:0] abs_set;    // magnitude of set frequency
    logic [MON_W:0]   freq_diff;  // output minus set, extended
    logic [MON_W-1:0] abs_diff;   // magnitude of the difference
    logic [MON_W-1:0] cur_rel;    // current release threshold
    logic [MON_W-1:0] ov_rel;     // voltage release threshold
    logic [MON_W-1:0] rel_a;      // release level a
    logic [MON_W-1:0] rel_b;      // release level b
    logic             run_any;    // running or inching
    logic [15:0]      cond;       // condition per function code

    // magnitudes and thresholds, saturating subtraction for the voltage and detect levels
    // saturation keeps a small level from wrapping
    always_comb begin
        abs_out   = drv.out_freq[MON_W-1] ? MON_W'(-drv.out_freq) : drv.out_freq;
        abs_set   = drv.set_freq[MON_W-1] ? MON_W'(-drv.set_freq) : drv.set_freq;
        freq_diff = {drv.out_freq[MON_W-1], drv.out_freq} - {drv.set_freq[MON_W-1], drv.set_freq};
        abs_diff  = freq_diff[MON_W] ? MON_W'(-freq_diff) : freq_diff[MON_W-1:0];
        cur_rel   = st_q.cur_lim - MON_W'(st_q.cur_lim / MON_W'(CUR_HYST_DIV));
        ov_rel    = (st_q.ov_stall > OV_HYST_VOLTS) ? st_q.ov_stall - OV_HYST_VOLTS : '0;
        rel_a     = (st_q.lvl_a > st_q.hyst_a) ? st_q.lvl_a - st_q.hyst_a : '0;
        rel_b     = (st_q.lvl_b > st_q.hyst_b) ? st_q.lvl_b - st_q.hyst_b : '0;
        run_any   = drv.running || drv.jog_run;
    end

    ////////////////////////////////////////////////////////////////////////////
    // condition table indexed by function code
    // every code is evaluated, selects only pick one
    always_comb begin
        cond = '0;
        cond[0]  = 1'b0;
        cond[1]  = drv.norm_run || drv.jog_run;
        cond[2]  = drv.running && (abs_diff <= st_q.reach_w);
        cond[3]  = st_q.det_a;
        cond[4]  = st_q.det_b;
        cond[5]  = drv.running && drv.reverse;
        cond[6]  = drv.jog_run;
        cond[7]  = drv.fault;
        cond[8]  = drv.ready;
        cond[9]  = run_any && (abs_out >= st_q.upper) && (abs_set >= st_q.upper);
        cond[10] = run_any && (abs_out <= st_q.lower) && (abs_set <= st_q.lower);
        cond[11] = st_q.cur_f;
        cond[12] = st_q.ov_f;
        cond[13] = drv.seq_done;
        cond[14] = drv.pulse_cnt >= st_q.set_cnt;
        cond[15] = drv.pulse_cnt >= st_q.des_cnt;
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        st_d = st_q;
        // stopping clears a detect flag before any set
        // detect a hysteresis
        if (!drv.running || abs_out <= rel_a) begin
            st_d.det_a = 1'b0;
        end else if (abs_out > st_q.lvl_a) begin
            st_d.det_a = 1'b1;
        end
        if (!drv.running || abs_out <= rel_b) begin
            st_d.det_b = 1'b0;
        end else if (abs_out > st_q.lvl_b) begin
            st_d.det_b = 1'b1;
        end
        if (drv.out_cur >= st_q.cur_lim) begin
            st_d.cur_f = 1'b1;
        end else if (drv.out_cur <= cur_rel) begin
            st_d.cur_f = 1'b0;
        end
        if (drv.bus_volt >= st_q.ov_stall) begin
            st_d.ov_f = 1'b1;
        end else if (drv.bus_volt <= ov_rel) begin
            st_d.ov_f = 1'b0;
        end
        for (int i = 0; i < NUM_OUTS; i++) begin
            if (st_q.sel[i] <= FN_DES_CNT) begin
                st_d.outs[i] = cond[st_q.sel[i][3:0]];
            end else begin
                st_d.outs[i] = 1'b0;
            end
        end
        if (!exp_card_fitted) begin
            st_d.outs[4] = 1'b0;
        end
        // ahb data phase
        st_d.rdata = '0;
        if (st_q.cap.pend && st_q.cap.write) begin
            unique case (st_q.cap.addr)
                OUT1_SEL_OFS:  st_d.sel[0]   = hwdata[SEL_W-1:0];
                OUT2_SEL_OFS:  st_d.sel[1]   = hwdata[SEL_W-1:0];
                RLY1_SEL_OFS:  st_d.sel[2]   = hwdata[SEL_W-1:0];
                RLY2_SEL_OFS:  st_d.sel[3]   = hwdata[SEL_W-1:0];
                EXP_SEL_OFS:   st_d.sel[4]   = hwdata[SEL_W-1:0];
                REACH_W_OFS:   st_d.reach_w  = hwdata[MON_W-1:0];
                LVL_A_OFS:     st_d.lvl_a    = hwdata[MON_W-1:0];
                HYST_A_OFS:    st_d.hyst_a   = hwdata[MON_W-1:0];
                LVL_B_OFS:     st_d.lvl_b    = hwdata[MON_W-1:0];
                HYST_B_OFS:    st_d.hyst_b   = hwdata[MON_W-1:0];
                UPPER_LIM_OFS: st_d.upper    = hwdata[MON_W-1:0];
                LOWER_LIM_OFS: st_d.lower    = hwdata[MON_W-1:0];
                CUR_LIM_OFS:   st_d.cur_lim  = hwdata[MON_W-1:0];
                OV_STALL_OFS:  st_d.ov_stall = hwdata[MON_W-1:0];
                SET_CNT_OFS:   st_d.set_cnt  = hwdata[MON_W-1:0];
                DES_CNT_OFS:   st_d.des_cnt  = hwdata[MON_W-1:0];
                default: begin
                    // unmapped or read-only, write ignored
                end
            endcase
        end
        // address phase capture
        // hsize is not decoded, registers are whole words
        st_d.cap.pend  = hsel && hready && htrans[1];
        st_d.cap.write = hwrite;
        st_d.cap.addr  = haddr[7:0];
        // read data registered at the same edge as the capture
        // a read overlapping a write phase sees the old value
        if (hsel && hready && htrans[1] && !hwrite) begin
            unique case (haddr[7:0])
                OUT1_SEL_OFS:  st_d.rdata = {16'h0000, st_q.sel[0]};
                OUT2_SEL_OFS:  st_d.rdata = {16'h0000, st_q.sel[1]};
                RLY1_SEL_OFS:  st_d.rdata = {16'h0000, st_q.sel[2]};
                RLY2_SEL_OFS:  st_d.rdata = {16'h0000, st_q.sel[3]};
                EXP_SEL_OFS:   st_d.rdata = {16'h0000, st_q.sel[4]};
                REACH_W_OFS:   st_d.rdata = {16'h0000, st_q.reach_w};
                LVL_A_OFS:     st_d.rdata = {16'h0000, st_q.lvl_a};
                HYST_A_OFS:    st_d.rdata = {16'h0000, st_q.hyst_a};
                LVL_B_OFS:     st_d.rdata = {16'h0000, st_q.lvl_b};
                HYST_B_OFS:    st_d.rdata = {16'h0000, st_q.hyst_b};
                UPPER_LIM_OFS: st_d.rdata = {16'h0000, st_q.upper};
                LOWER_LIM_OFS: st_d.rdata = {16'h0000, st_q.lower};
                CUR_LIM_OFS:   st_d.rdata = {16'h0000, st_q.cur_lim};
                OV_STALL_OFS:  st_d.rdata = {16'h0000, st_q.ov_stall};
                SET_CNT_OFS:   st_d.rdata = {16'h0000, st_q.set_cnt};
                DES_CNT_OFS:   st_d.rdata = {16'h0000, st_q.des_cnt};
                STATUS_OFS:    st_d.rdata = {23'h000000, st_q.ov_f, st_q.cur_f,
                                             st_q.det_b, st_q.det_a, st_q.outs};
                default:       st_d.rdata = '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            st_q          <= '0;
            st_q.sel[0]   <= OUT1_SEL_RST;
            st_q.sel[1]   <= OUT2_SEL_RST;
            st_q.sel[2]   <= RLY1_SEL_RST;
            st_q.sel[3]   <= RLY2_SEL_RST;
            st_q.sel[4]   <= EXP_SEL_RST;
            // thresholds out of reach until software sets them
            st_q.cur_lim  <= THRESH_RST;
            st_q.ov_stall <= THRESH_RST;
            st_q.upper    <= THRESH_RST;
            st_q.set_cnt  <= THRESH_RST;
            st_q.des_cnt  <= THRESH_RST;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // terminals and read data straight from flops
    // the slave never stalls and always answers okay
    always_comb begin
        digital_out_one       = st_q.outs[0];
        digital_out_two       = st_q.outs[1];
        relay_out_one         = st_q.outs[2];
        relay_out_two         = st_q.outs[3];
        expansion_digital_out = st_q.outs[4];
        hrdata                = st_q.rdata;
        hreadyout             = 1'b1;
        hresp                 = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    // all checks sample on the control clock
    // fault relay follows fault
    chk_fault_relay_follow: assert property (@(posedge mclk) disable iff (!rstn)
        (st_q.sel[2] == FN_FAULT && $stable(st_q.sel[2])) |=> (relay_out_one == $past(drv.fault)))
        else $error("relay one does not follow fault");

    chk_code_zero_low: assert property (@(posedge mclk) disable iff (!rstn)
        (st_q.sel[0] == FN_NONE) |=> !digital_out_one)
        else $error("code zero terminal went active");

    chk_undef_code_low: assert property (@(posedge mclk) disable iff (!rstn)
        (st_q.sel[0] > FN_DES_CNT) |=> !digital_out_one)
        else $error("undefined code terminal went active");

    chk_exp_card_gate: assert property (@(posedge mclk) disable iff (!rstn)
        !exp_card_fitted |=> !expansion_digital_out)
        else $error("expansion output active without card");

    chk_det_a_stop: assert property (@(posedge mclk) disable iff (!rstn)
        !drv.running |=> !st_q.det_a)
        else $error("detect a held while stopped");

    chk_det_b_stop: assert property (@(posedge mclk) disable iff (!rstn)
        !drv.running |=> !st_q.det_b)
        else $error("detect b held while stopped");

    chk_det_a_set: assert property (@(posedge mclk) disable iff (!rstn)
        (drv.running && abs_out > st_q.lvl_a) |=> st_q.det_a)
        else $error("detect a not set above level");

    chk_det_b_set: assert property (@(posedge mclk) disable iff (!rstn)
        (drv.running && abs_out > st_q.lvl_b) |=> st_q.det_b)
        else $error("detect b not set above level");

    chk_cur_set_limit: assert property (@(posedge mclk) disable iff (!rstn)
        (drv.out_cur >= st_q.cur_lim) |=> st_q.cur_f)
        else $error("current flag not set at limit");

    chk_cur_release: assert property (@(posedge mclk) disable iff (!rstn)
        (drv.out_cur < st_q.cur_lim && drv.out_cur <= cur_rel) |=> !st_q.cur_f)
        else $error("current flag not released");

    chk_ov_set_stall: assert property (@(posedge mclk) disable iff (!rstn)
        (drv.bus_volt >= st_q.ov_stall) |=> st_q.ov_f)
        else $error("voltage flag not set at stall");

    chk_ov_hold_band: assert property (@(posedge mclk) disable iff (!rstn)
        (drv.bus_volt < st_q.ov_stall && drv.bus_volt > ov_rel) |=> (st_q.ov_f == $past(st_q.ov_f)))
        else $error("voltage flag changed in band");

    chk_reset_flags_clear: assert property (@(posedge mclk)
        !rstn |=> (!st_q.det_a && !st_q.det_b && !st_q.cur_f && !st_q.ov_f))
        else $error("hysteresis flag set after reset");

    chk_out1_registered: assert property (@(posedge mclk) disable iff (!rstn)
        (st_q.sel[0] == FN_JOG && $stable(st_q.sel[0])) |=> (digital_out_one == $past(drv.jog_run)))
        else $error("terminal one not registered inching state");

    chk_reverse_out: assert property (@(posedge mclk) disable iff (!rstn)
        (st_q.sel[0] == FN_REV) |=> (digital_out_one == ($past(drv.running) && $past(drv.reverse))))
        else $error("terminal one not following reverse run");

    chk_count_reach: assert property (@(posedge mclk) disable iff (!rstn)
        (st_q.sel[0] == FN_SET_CNT) |=> (digital_out_one == ($past(drv.pulse_cnt) >= $past(st_q.set_cnt))))
        else $error("terminal one not following count reach");

    chk_ready_relay: assert property (@(posedge mclk) disable iff (!rstn)
        (st_q.sel[3] == FN_READY) |=> (relay_out_two == $past(drv.ready)))
        else $error("relay two does not follow ready");

endmodule

`default_nettype wire

//--- outsel_pkg.sv
package outsel_pkg;

    // terminal count and select width
    localparam int NUM_OUTS  = 5;
    localparam int SEL_W     = 16;
    localparam int MON_W     = 16;

    // register byte offsets on the bus
    localparam logic [7:0] OUT1_SEL_OFS   = 8'h00;
    localparam logic [7:0] OUT2_SEL_OFS   = 8'h04;
    localparam logic [7:0] RLY1_SEL_OFS   = 8'h08;
    localparam logic [7:0] RLY2_SEL_OFS   = 8'h0c;
    localparam logic [7:0] EXP_SEL_OFS    = 8'h10;
    localparam logic [7:0] REACH_W_OFS    = 8'h14;
    localparam logic [7:0] LVL_A_OFS      = 8'h18;
    localparam logic [7:0] HYST_A_OFS     = 8'h1c;
    localparam logic [7:0] LVL_B_OFS      = 8'h20;
    localparam logic [7:0] HYST_B_OFS     = 8'h24;
    localparam logic [7:0] UPPER_LIM_OFS  = 8'h28;
    localparam logic [7:0] LOWER_LIM_OFS  = 8'h2c;
    localparam logic [7:0] CUR_LIM_OFS    = 8'h30;
    localparam logic [7:0] OV_STALL_OFS   = 8'h34;
    localparam logic [7:0] SET_CNT_OFS    = 8'h38;
    localparam logic [7:0] DES_CNT_OFS    = 8'h3c;
    localparam logic [7:0] STATUS_OFS     = 8'h40;

    // function select reset values
    localparam logic [SEL_W-1:0] OUT1_SEL_RST = 16'h0001;
    localparam logic [SEL_W-1:0] OUT2_SEL_RST = 16'h0003;
    localparam logic [SEL_W-1:0] RLY1_SEL_RST = 16'h0007;
    localparam logic [SEL_W-1:0] RLY2_SEL_RST = 16'h0008;
    localparam logic [SEL_W-1:0] EXP_SEL_RST  = 16'h0000;
    // threshold reset value, full scale
    localparam logic [MON_W-1:0] THRESH_RST   = 16'hffff;

    // hysteresis: voltage offset in monitor units, current as divisor of the limit
    localparam logic [MON_W-1:0] OV_HYST_VOLTS  = 16'h000a;
    localparam int               CUR_HYST_DIV   = 20;

    // function codes
    localparam logic [SEL_W-1:0] FN_NONE     = 16'h0000;
    localparam logic [SEL_W-1:0] FN_RUN      = 16'h0001;
    localparam logic [SEL_W-1:0] FN_REACH    = 16'h0002;
    localparam logic [SEL_W-1:0] FN_DET_A    = 16'h0003;
    localparam logic [SEL_W-1:0] FN_DET_B    = 16'h0004;
    localparam logic [SEL_W-1:0] FN_REV      = 16'h0005;
    localparam logic [SEL_W-1:0] FN_JOG      = 16'h0006;
    localparam logic [SEL_W-1:0] FN_FAULT    = 16'h0007;
    localparam logic [SEL_W-1:0] FN_READY    = 16'h0008;
    localparam logic [SEL_W-1:0] FN_UPPER    = 16'h0009;
    localparam logic [SEL_W-1:0] FN_LOWER    = 16'h000a;
    localparam logic [SEL_W-1:0] FN_CUR_LIM  = 16'h000b;
    localparam logic [SEL_W-1:0] FN_OV_STALL = 16'h000c;
    localparam logic [SEL_W-1:0] FN_SEQ_DONE = 16'h000d;
    localparam logic [SEL_W-1:0] FN_SET_CNT  = 16'h000e;
    localparam logic [SEL_W-1:0] FN_DES_CNT  = 16'h000f;

    // drive status bundle
    typedef struct packed {
        logic             norm_run;    // normal running or stopping
        logic             jog_run;     // inching running or stopping
        logic             running;     // actively running
        logic             reverse;     // reverse direction
        logic             fault;       // fault state
        logic             ready;       // init done, ready
        logic             seq_done;    // sequencer finished pass(es)
        logic [MON_W-1:0] out_freq;    // signed output frequency
        logic [MON_W-1:0] set_freq;    // set frequency
        logic [MON_W-1:0] out_cur;     // output current
        logic [MON_W-1:0] bus_volt;    // bus voltage
        logic [MON_W-1:0] pulse_cnt;   // input pulse count
    } drive_stat_s;

    // ahb address phase capture
    typedef struct packed {
        logic       pend;              // data phase pending
        logic       write;             // write transfer
        logic [7:0] addr;              // captured byte address
    } ahb_cap_s;

endpackage

//--- terminal_load.sv
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// external load wired to the five terminals
module terminal_load (
    input  wire logic       o1,   // terminal one
    input  wire logic       o2,   // terminal two
    input  wire logic       r1,   // relay one
    input  wire logic       r2,   // relay two
    input  wire logic       ox,   // expansion terminal
    output logic      [4:0] seen  // levels seen by load
);
    // load reads the levels as wired, no latency
    assign seen = {ox, r2, r1, o2, o1};
endmodule

`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top
    import outsel_pkg::*;
;
    logic        mclk, rstn, hsel, hwrite, hreadyout, hresp, fitted;  // clock, reset, bus
    logic [31:0] haddr, hwdata, hrdata, rd;                           // bus words
    logic [1:0]  htrans;                                              // transfer type
    logic [2:0]  hsize;                                               // transfer size
    logic        o1, o2, r1, r2, ox;                                  // terminals
    logic [4:0]  seen;                                                // load view
    drive_stat_s drv;                                                 // drive status
    int          fail_count, checks;                                  // counters
    // parameter table and values
    localparam logic [7:0]  POFS [11] = '{REACH_W_OFS, LVL_A_OFS, HYST_A_OFS, LVL_B_OFS, HYST_B_OFS,
        UPPER_LIM_OFS, LOWER_LIM_OFS, CUR_LIM_OFS, OV_STALL_OFS, SET_CNT_OFS, DES_CNT_OFS};
    localparam logic [15:0] PVAL [11] = '{16'h0005, 16'h0064, 16'h000a, 16'h00c8, 16'h0014,
        16'h03e8, 16'h0032, 16'h00c8, 16'h01f4, 16'h0014, 16'h001e};
    localparam logic [7:0]  SOFS [5]  = '{OUT1_SEL_OFS, OUT2_SEL_OFS, RLY1_SEL_OFS, RLY2_SEL_OFS, EXP_SEL_OFS};
    localparam logic [15:0] SRST [5]  = '{OUT1_SEL_RST, OUT2_SEL_RST, RLY1_SEL_RST, RLY2_SEL_RST, EXP_SEL_RST};
    // hysteresis walk: frequency, current, voltage
    localparam logic [15:0] FQ [5] = '{16'h03e8, 16'h005f, 16'h005a, 16'h005f, 16'h0065};
    localparam logic [15:0] CU [5] = '{16'h00c8, 16'h00c3, 16'h00be, 16'h00c3, 16'h00c9};
    localparam logic [15:0] VO [5] = '{16'h01f4, 16'h01ef, 16'h01ea, 16'h01ef, 16'h01f5};

    output_terminal_function_selector i_output_terminal_function_selector (
        .mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .exp_card_fitted(fitted), .drv(drv), .digital_out_one(o1), .digital_out_two(o2),
        .relay_out_one(r1), .relay_out_two(r2), .expansion_digital_out(ox));
    terminal_load i_terminal_load (.o1(o1), .o2(o2), .r1(r1), .r2(r2), .ox(ox), .seen(seen));

    ////////////////////////////////////////////////////////////////////////////
    // clock, 4 ns period
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // compare helpers
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: terminal %b expected %b", $time, got, exp);
        end
    endtask
    task automatic cmp_vec(input logic [4:0] got, input logic [4:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: load sees %b expected %b", $time, got, exp);
        end
    endtask

    // one single ahb transfer, entered just after a rising edge
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int   n;
        logic late;
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        hsize  <= 3'b010;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        late = (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        rd = hrdata;
        if (late || hreadyout !== 1'b1) begin
            fail_count++;
            $display("mismatch at %0t: no ready from slave", $time);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h00000000);
        cmp_word(rd, exp);
        cmp_bit(hresp, 1'b0);
    endtask
    // write then let write and hysteresis latency land
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
        repeat (4) @(posedge mclk);
    endtask

    // walk every code on terminal one against an expected mask
    task automatic sweep(input logic [16:0] mask);
        for (int c = 0; c < 17; c++) begin
            wr(OUT1_SEL_OFS, 32'(c));
            cmp_bit(o1, mask[c]);
        end
    endtask

    task automatic summarize;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        summarize();
    end

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        drive_stat_s s;
        fail_count = 0;
        checks = 0;
        {hsel, hwrite, htrans, hsize, haddr, hwdata} <= '0;
        fitted <= 1'b1;
        s = '0;
        s.ready = 1'b1;
        drv <= s;
        rstn <= 1'b0;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        // reset values, readback, unmapped place
        for (int i = 0; i < 5; i++) rchk(SOFS[i], {16'h0000, SRST[i]});
        for (int i = 0; i < 11; i++) ahb(1'b1, POFS[i], {16'h0000, PVAL[i]});
        for (int i = 0; i < 11; i++) rchk(POFS[i], {16'h0000, PVAL[i]});
        ahb(1'b1, 8'h80, 32'hffffffff);
        rchk(8'h80, 32'h00000000);
        // idle and ready only
        sweep(17'h00100);
        // running reverse at upper limit, fault, limits reached
        s = '{norm_run: 1'b1, running: 1'b1, reverse: 1'b1, fault: 1'b1, ready: 1'b1, seq_done: 1'b1,
              out_freq: 16'h03e8, set_freq: 16'h03e8, out_cur: 16'h00c8, bus_volt: 16'h01f4,
              pulse_cnt: 16'h001e, default: '0};
        drv <= s;
        sweep(17'h0fbbe);
        wr(OUT1_SEL_OFS, 32'h00000001);
        wr(EXP_SEL_OFS, 32'h00000001);
        cmp_vec(seen, 5'b11111);
        fitted <= 1'b0;
        repeat (3) @(posedge mclk);
        cmp_vec(seen, 5'b01111);
        // inching stop at lower limit, thresholds in hold band
        s = '{jog_run: 1'b1, ready: 1'b1, out_freq: 16'h0032, set_freq: 16'h0032,
              out_cur: 16'h00c3, bus_volt: 16'h01ef, pulse_cnt: 16'h0019, default: '0};
        drv <= s;
        sweep(17'h05d42);
        // hysteresis walk on three terminals at once
        wr(OUT1_SEL_OFS, {16'h0000, FN_DET_A});
        wr(OUT2_SEL_OFS, {16'h0000, FN_CUR_LIM});
        wr(RLY1_SEL_OFS, {16'h0000, FN_OV_STALL});
        s.running = 1'b1;
        s.norm_run = 1'b1;
        for (int i = 0; i < 5; i++) begin
            s.out_freq = FQ[i];
            s.out_cur = CU[i];
            s.bus_volt = VO[i];
            drv <= s;
            repeat (4) @(posedge mclk);
            cmp_bit(o1, i == 0 || i == 1 || i == 4);
            cmp_bit(o2, i == 0 || i == 1 || i == 4);
            cmp_bit(r1, i == 0 || i == 1 || i == 4);
        end
        rchk(STATUS_OFS, 32'h000001af);
        // reset in mid-run: terminals drop, selects restart
        rstn <= 1'b0;
        repeat (2) @(posedge mclk);
        cmp_vec(seen, 5'b00000);
        rstn <= 1'b1;
        rchk(OUT1_SEL_OFS, {16'h0000, OUT1_SEL_RST});
        repeat (2) @(posedge mclk);
        cmp_vec(seen, 5'b01011);
        summarize();
    end
endmodule

`default_nettype wire
